// ---- design/delay_edge_detector.v ----
// Programmable delay / edge detector with deglitch filter and reset pin trigger.
// Assumes AXI4-Lite master on i_sys_clk; cell inputs and pin arrive asynchronously.
//
// Operation
// - Two-bit mode: rise, fall, both-edge detect, delay
// - Two-bit delay select: 125/250/375/500 ns
// - Output source: delay cell or deglitch filter
// - Filter polarity bit inverts deglitch filter output
// - Reset pin: enable, level/edge, rise/fall
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "delay_edge_map.vh"

module delay_edge_detector #(
  parameter FILT_CYC = 4
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_nrst,
  // AXI4-Lite write address
  input wire [`ADDR_W-1:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // AXI4-Lite read address
  input wire [`ADDR_W-1:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // Matrix side
  input wire i_delay_in,
  input wire i_filter_in,
  input wire i_reset_input_pin,
  output reg o_cell_out,
  output reg o_pin_reset
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Least time, so round up to whole cycles
  function [`DLY_CNT_W-1:0] dly_cycles;
    input [1:0] sel;
    reg [31:0] ns;
    reg [31:0] cyc;
    begin
      ns = (sel + 32'd1) * `DLY_STEP_NS;
      cyc = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      dly_cycles = cyc[`DLY_CNT_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  reg [`CFG_W-1:0] cfg_r;
  wire wr_go;
  wire rd_go;
  wire wr_hit;

  // Both halves taken together; a lone channel waits for its partner
  assign wr_go = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
  assign o_s_axi_awready = wr_go;
  assign o_s_axi_wready = wr_go;
  assign rd_go = i_s_axi_arvalid & ~o_s_axi_rvalid;
  assign o_s_axi_arready = rd_go;
  assign wr_hit = (i_s_axi_awaddr[`ADDR_W-1:2] == `REG_CFG_IDX);

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r <= `CFG_RESET;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (wr_go) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_hit && i_s_axi_wstrb[0])
          cfg_r[7:0] <= i_s_axi_wdata[7:0];
        if (wr_hit && i_s_axi_wstrb[1])
          cfg_r[`CFG_RST_EN] <= i_s_axi_wdata[`CFG_RST_EN];
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [4:0] status_w;

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (rd_go) begin
        o_s_axi_rvalid <= 1'b1;
        case (i_s_axi_araddr[`ADDR_W-1:2])
          `REG_CFG_IDX: begin
            o_s_axi_rdata <= {23'h000000, cfg_r};
            o_s_axi_rresp <= `RESP_OKAY;
          end
          `REG_STATUS_IDX: begin
            o_s_axi_rdata <= {27'h0000000, status_w};
            o_s_axi_rresp <= `RESP_OKAY;
          end
          default: begin
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  wire [1:0] mode = cfg_r[`CFG_EDGE_MSB:`CFG_EDGE_LSB];
  wire [1:0] dsel = cfg_r[`CFG_DSEL_MSB:`CFG_DSEL_LSB];

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] din_s_r;
  reg [1:0] fin_s_r;
  reg [1:0] pin_s_r;
  reg din_d_r;
  reg pin_d_r;

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      din_s_r <= 2'h0;
      fin_s_r <= 2'h0;
      pin_s_r <= 2'h0;
      din_d_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      din_s_r <= {din_s_r[0], i_delay_in};
      fin_s_r <= {fin_s_r[0], i_filter_in};
      pin_s_r <= {pin_s_r[0], i_reset_input_pin};
      din_d_r <= din_s_r[1];
      pin_d_r <= pin_s_r[1];
    end
  end

  wire din = din_s_r[1];
  wire din_rise = din & ~din_d_r;
  wire din_fall = ~din & din_d_r;

  // ----------------------------------------------------------------
  // Delay / edge detector cell
  // ----------------------------------------------------------------
  reg [`MAX_DLY_CYC-1:0] line_r;
  reg [`DLY_CNT_W-1:0] pulse_cnt_r;
  reg dly_out_r;
  reg edge_hit;
  wire [`DLY_CNT_W-1:0] dly_cyc = dly_cycles(dsel);

  always @* begin
    case (mode)
      `MODE_RISE: edge_hit = din_rise;
      `MODE_FALL: edge_hit = din_fall;
      `MODE_BOTH: edge_hit = din_rise | din_fall;
      default: edge_hit = 1'b0;
    endcase
  end

  // Line always shifts so a mode change finds history already in place
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      line_r <= {`MAX_DLY_CYC{1'b0}};
      pulse_cnt_r <= {`DLY_CNT_W{1'b0}};
      dly_out_r <= 1'b0;
    end else begin
      line_r <= {line_r[`MAX_DLY_CYC-2:0], din};
      if (edge_hit)
        pulse_cnt_r <= dly_cyc;
      else if (pulse_cnt_r != {`DLY_CNT_W{1'b0}})
        pulse_cnt_r <= pulse_cnt_r - 1'b1;
      if (mode == `MODE_DELAY)
        dly_out_r <= line_r[dly_cyc - 2'd2];
      else
        dly_out_r <= edge_hit | (pulse_cnt_r > 1);
    end
  end

  // ----------------------------------------------------------------
  // Deglitch filter
  // ----------------------------------------------------------------
  // Output moves only after input holds steady FILT_CYC cycles
  reg [7:0] filt_cnt_r;
  reg filt_r;

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      filt_cnt_r <= 8'h00;
      filt_r <= 1'b0;
    end else if (fin_s_r[1] == filt_r) begin
      filt_cnt_r <= 8'h00;
    end else if (filt_cnt_r >= FILT_CYC - 1) begin
      filt_r <= fin_s_r[1];
      filt_cnt_r <= 8'h00;
    end else begin
      filt_cnt_r <= filt_cnt_r + 8'h01;
    end
  end

  wire filt_pol = filt_r ^ cfg_r[`CFG_FILT_INV];

  // ----------------------------------------------------------------
  // Shared output and reset pin trigger
  // ----------------------------------------------------------------
  reg pin_trig;

  always @* begin
    if (!cfg_r[`CFG_RST_EN])
      pin_trig = 1'b0;
    else if (cfg_r[`CFG_RST_LEVEL])
      pin_trig = pin_s_r[1];
    else if (cfg_r[`CFG_RST_FALL])
      pin_trig = ~pin_s_r[1] & pin_d_r;
    else
      pin_trig = pin_s_r[1] & ~pin_d_r;
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cell_out <= 1'b0;
      o_pin_reset <= 1'b0;
    end else begin
      o_cell_out <= cfg_r[`CFG_OUT_SEL] ? filt_pol : dly_out_r;
      o_pin_reset <= pin_trig;
    end
  end

  assign status_w = {o_pin_reset, o_cell_out, filt_pol, dly_out_r, din};

endmodule // delay_edge_detector

// ---- design/delay_edge_map.vh ----
// Constants for the delay / edge detector macrocell and its register map.
// Assumes inclusion by design files only; holds definitions and nothing else.
`ifndef DELAY_EDGE_MAP_VH
`define DELAY_EDGE_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define REG_CFG_ADDR 4'h0
`define REG_STATUS_ADDR 4'h4
`define REG_CFG_IDX 2'h0
`define REG_STATUS_IDX 2'h1
`define ADDR_W 4

// ----------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------
`define CFG_EDGE_LSB 0
`define CFG_EDGE_MSB 1
`define CFG_DSEL_LSB 2
`define CFG_DSEL_MSB 3
`define CFG_OUT_SEL 4
`define CFG_FILT_INV 5
`define CFG_RST_FALL 6
`define CFG_RST_LEVEL 7
`define CFG_RST_EN 8
`define CFG_W 9
`define CFG_RESET 9'h000

// ----------------------------------------------------------------
// Edge mode encodings
// ----------------------------------------------------------------
`define MODE_RISE 2'h0
`define MODE_FALL 2'h1
`define MODE_BOTH 2'h2
`define MODE_DELAY 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define DLY_STEP_NS 125
`define MAX_DLY_CYC 50
`define DLY_CNT_W 6

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- test/delay_edge_detector_properties.sv ----
// Bus handshake checker for delay_edge_detector.
// Assumes it is bound onto the top module's ports.
`timescale 1ns/1ns
module delay_edge_checker (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire [3:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire [1:0] o_s_axi_bresp,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_aw_ready_term: assert property (o_s_axi_awready == (i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid))
    else $error("awready term wrong");
  a_ar_ready_term: assert property (o_s_axi_arready == (i_s_axi_arvalid && !o_s_axi_rvalid))
    else $error("arready term wrong");
  a_b_after_write: assert property (o_s_axi_awready |=> o_s_axi_bvalid)
    else $error("no write response");
  a_b_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  a_r_after_read: assert property (o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("no read data");
  a_r_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  a_cfg_okay: assert property (o_s_axi_awready && i_s_axi_awaddr[3:2] == 2'h0 |=> o_s_axi_bresp == 2'h0)
    else $error("config write refused");
  a_bad_slverr: assert property (o_s_axi_awready && i_s_axi_awaddr[3:2] != 2'h0 |=> o_s_axi_bresp == 2'h2)
    else $error("bad write accepted");
endmodule // delay_edge_checker
bind delay_edge_detector delay_edge_checker chk_u (.*);

// ---- test/delay_edge_detector_test.sv ----
// Bench for delay_edge_detector: random configs, output cycles counted.
// Assumes matrix_model drives the cell inputs and the checker is bound.
`timescale 1ns/1ns
module delay_edge_detector_test;
  reg i_sys_clk = 0, i_nrst = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  reg i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  reg [3:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0, i_s_axi_wstrb = 4'hF;
  reg [31:0] i_s_axi_wdata = 0, cfg, data;
  reg [2:0] req = 0;
  reg [1:0] resp;
  wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire i_delay_in, i_filter_in, i_reset_input_pin, o_cell_out, o_pin_reset;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata;
  integer miscompares = 0, cmp_count = 0, i, k, n, cc, pc;
  delay_edge_detector dut_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready), .i_delay_in(i_delay_in),
    .i_filter_in(i_filter_in), .i_reset_input_pin(i_reset_input_pin), .o_cell_out(o_cell_out),
    .o_pin_reset(o_pin_reset));
  matrix_model mdl_u (.i_sys_clk(i_sys_clk), .i_req(req), .o_delay_in(i_delay_in),
    .o_filter_in(i_filter_in), .o_reset_input_pin(i_reset_input_pin));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait guard; a spent bound ends the run
  function bit go;
    n = n + 1;
    go = n < 100;
  endfunction
  task wreg(input [3:0] a, input [31:0] d);
    begin
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1;
      i_s_axi_wvalid <= 1;
      n = 0;
      do @(posedge i_sys_clk); while (o_s_axi_awready !== 1'b1 && go());
      i_s_axi_awvalid <= 0;
      i_s_axi_wvalid <= 0;
      // Late bready so the response must stand a while
      repeat ($urandom % 3) @(posedge i_sys_clk);
      i_s_axi_bready <= 1;
      do @(posedge i_sys_clk); while (o_s_axi_bvalid !== 1'b1 && go());
      resp = o_s_axi_bresp;
      i_s_axi_bready <= 0;
      if (n >= 100) check(0, 1);
      if (n >= 100) final_report;
    end
  endtask
  task rreg(input [3:0] a);
    begin
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1;
      n = 0;
      do @(posedge i_sys_clk); while (o_s_axi_arready !== 1'b1 && go());
      i_s_axi_arvalid <= 0;
      repeat ($urandom % 3) @(posedge i_sys_clk);
      i_s_axi_rready <= 1;
      do @(posedge i_sys_clk); while (o_s_axi_rvalid !== 1'b1 && go());
      data = o_s_axi_rdata;
      resp = o_s_axi_rresp;
      i_s_axi_rready <= 0;
      if (n >= 100) check(0, 1);
      if (n >= 100) final_report;
    end
  endtask
  // Cell and pin high for the first 60 of 200 cycles; output-high cycles counted over all 200
  task run_pins;
    begin
      cc = 0;
      pc = 0;
      for (i = 0; i < 200; i = i + 1) begin
        req <= (i < 60) ? 3'h5 : 3'h0;
        @(posedge i_sys_clk);
        cc = cc + o_cell_out;
        pc = pc + o_pin_reset;
      end
    end
  endtask
  function integer exp_cell(input [31:0] c);
    integer nd;
    begin
      nd = ((c[3:2] + 32'd1) * 125 + 9) / 10;
      exp_cell = (c[1:0] == 2'h3) ? 60 : (c[1:0] == 2'h2) ? 2 * nd : nd;
    end
  endfunction
  function integer exp_pin(input [31:0] c);
    exp_pin = !c[8] ? 0 : c[7] ? 60 : 1;
  endfunction
  initial begin
    k = $urandom(32'h02C69DAE);
    repeat (10) @(posedge i_sys_clk);
    i_nrst <= 1;
    @(posedge i_sys_clk);
    for (k = 0; k < 12; k = k + 1) begin
      cfg = $urandom & 32'h1CF;
      if (k < 4) cfg[1:0] = k[1:0];
      wreg(4'h0, cfg);
      check(resp, 2'h0);
      rreg(4'h0);
      check(data, cfg);
      run_pins;
      check(cc, exp_cell(cfg));
      check(pc, exp_pin(cfg));
    end
    for (k = 0; k < 2; k = k + 1) begin
      wreg(4'h0, 32'h10 | (k << 5));
      req <= 3'h2;
      repeat (20) @(posedge i_sys_clk);
      check(o_cell_out, !k);
      req <= 3'h0;
      repeat (20) @(posedge i_sys_clk);
      check(o_cell_out, k);
    end
    // Glitch one cycle shorter than the filter's default hold time
    cc = 0;
    for (i = 0; i < 24; i = i + 1) begin
      req <= (i < 3) ? 3'h2 : 3'h0;
      @(posedge i_sys_clk);
      cc = cc + o_cell_out;
    end
    check(cc, 24);
    rreg(4'h4);
    check(resp, 2'h0);
    check(data, 32'hC);
    i_s_axi_wstrb <= 4'h2;
    wreg(4'h0, 32'h1FF);
    i_s_axi_wstrb <= 4'hF;
    check(resp, 2'h0);
    rreg(4'h0);
    check(data, 32'h130);
    i_nrst <= 0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1;
    @(posedge i_sys_clk);
    rreg(4'h0);
    check(data, 0);
    wreg(4'h4, 32'h1);
    check(resp, 2'h2);
    wreg(4'h8, 32'h1);
    check(resp, 2'h2);
    rreg(4'hC);
    check(resp, 2'h2);
    check(data, 0);
    final_report;
  end
endmodule // delay_edge_detector_test

// ---- test/matrix_model.sv ----
// Matrix-side model: drives the three cell inputs from bench requests.
// Assumes requests change just after i_sys_clk rising edges.
`timescale 1ns/1ns
module matrix_model (
  // Clock and request
  input wire i_sys_clk,
  input wire [2:0] i_req,
  // Lines toward the cell
  output reg o_delay_in,
  output reg o_filter_in,
  output reg o_reset_input_pin
);
  initial {o_reset_input_pin, o_filter_in, o_delay_in} = 3'h0;
  // Registered so every level change lands one edge after the request
  always @(posedge i_sys_clk) begin
    {o_reset_input_pin, o_filter_in, o_delay_in} <= i_req;
  end
endmodule // matrix_model
